// ==== rtl/flash_word_reader.sv ====
/*
 Single word fetch from the LAN region of the flash.
 Assumes a same-clock flash port: request held until a one-cycle acknowledge
 that carries the read data.
*/
`timescale 1ns/100ps

module flash_word_reader
   import nvm_loader_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetN,
   input  wire logic        start,
   input  wire logic [6:0]  wordIndex,
   input  wire logic        flashAck,
   input  wire logic [15:0] flashData,
   output      logic        flashReq,
   output      logic [7:0]  flashByteAddr,
   output      logic        done,
   output      logic [15:0] data
);

   reader_t r;
   reader_t next_r;

   // ==========================================================================
   // Request and acknowledge
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      unique case (r.state)
         RD_IDLE: begin
            if (start) begin
               next_r.state = RD_BUSY;
               next_r.flashReq = 1'b1;
               next_r.flashByteAddr = {wordIndex, 1'b0}; // [R19]
            end
         end
         RD_BUSY: begin
            if (flashAck) begin
               next_r.state = RD_IDLE;
               next_r.flashReq = 1'b0;
               next_r.done = 1'b1;
               next_r.data = flashData;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetN) begin
      if (!resetN) begin
         r <= '{state: RD_IDLE, flashReq: 1'b0, flashByteAddr: 8'h00, done: 1'b0,
                data: 16'h0000};
      end else begin
         r <= next_r;
      end
   end

   assign flashReq      = r.flashReq;
   assign flashByteAddr = r.flashByteAddr;
   assign done          = r.done;
   assign data          = r.data;

endmodule

// ==== rtl/lan_nvm_word_loader.sv ====
/*
 Loader of configuration words from the LAN image after the shared and the
 function reset events. Assumes reset requests and host writes are one-cycle
 pulses on mclk and the flash port follows flash_word_reader.
*/
`timescale 1ns/100ps

// Functional notes
// [R1] Station address bytes 2,1 / 4,3 / 6,5 come from words 0x00, 0x01, 0x02.
// [R2] Fetched station address drives the first receive address pair.
// [R3] Byte 1 bit 0 sits at the wire-first end, byte 6 bit 7 last.
// [R4] Byte 1 bit 0 flags multicast, bit 1 flags a local address.
// [R5] Shared reset re-reads address words and words 0x13 through 0x18.
// [R6] Function reset re-reads words 0x0A through 0x10.
// [R7] Aux supply with wake enable advertises wake from D3cold.
// [R8] Wake enable allows PME in any state and sets PME support bits.
// [R9] Image must hold init control bits 5 and 4 at zero.
// [R10] Init bit 3 lets the host write the subsystem identifier once.
// [R11] Init bit 2 drops the I/O space request and reserves BAR 2.
// [R12] Init bit 1 loads subsystem id from 0x0B and vendor from 0x0C.
// [R13] Init bit 0 loads the device identifier from word 0x0D.
// [R14] Subsystem identifier defaults to 0x0000.
// [R15] Words 0x0E and 0x0F are read but have no hardware function.
// [R16] Word 0x3F holds a software checksum over bytes 0x00 to 0x7D.
// [R17] Words 0x40 to 0x4A are read as physical-layer configuration.
// [R18] Shared init sign other than 10b stops loading, defaults stay.
// [R19] Image word N lives at byte offset 2N.
// [R20] Identifiers keep built-in defaults when their load bit is clear.
module lan_nvm_word_loader
   import nvm_loader_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        sharedResetReq,
   input  wire logic        functionResetReq,
   input  wire logic        flashAck,
   input  wire logic [15:0] flashData,
   input  wire logic        hostSsidWrite,
   input  wire logic [15:0] hostSsidData,
   output      logic        flashReq,
   output      logic [7:0]  flashByteAddr,
   output      logic [31:0] rxAddrLow,
   output      logic [15:0] rxAddrHigh,
   output      logic        rxAddrValid,
   output      logic        addrIsMulticast,
   output      logic        addrIsLocal,
   output      logic        imageValid,
   output      logic        loadBusy,
   output      pci_ident_t  ident,
   output      fn_advert_t  advert,
   output      logic [7:0]  lanD0Power,
   output      logic [4:0]  lanD3Power,
   output      logic [79:0] extConfig,
   output      logic        phyCfgValid,
   output      logic [3:0]  phyCfgIndex,
   output      logic [15:0] phyCfgData
);

   // ==========================================================================
   // Reset release
   logic       rstMeta;
   logic       resetN;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rstMeta <= 1'b0;
         resetN  <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         resetN  <= rstMeta;
      end
   end

   // ==========================================================================
   // Word fetch
   logic        rdDone;
   logic [15:0] rdData;
   loader_t     s;
   loader_t     next_s;

   flash_word_reader u_reader (
      .mclk          (mclk),
      .resetN        (resetN),
      .start         (s.fetchStart),
      .wordIndex     (s.word),
      .flashAck      (flashAck),
      .flashData     (flashData),
      .flashReq      (flashReq),
      .flashByteAddr (flashByteAddr),
      .done          (rdDone),
      .data          (rdData)
   );

   // ==========================================================================
   // Load sequence order
   function automatic logic [7:0] follow(input logic shared, input logic [6:0] w);
      logic       last;
      logic [6:0] nw;
      last = 1'b0;
      nw   = w + 7'h01;
      if (shared) begin
         if (w == WORD_SHARED_INIT) begin
            nw = WORD_ADDR_FIRST;
         end else if (w == WORD_ADDR_LAST) begin
            nw = WORD_EXT_FIRST;
         end else if (w == WORD_EXT_LAST) begin
            nw = WORD_PHY_FIRST;
         end else if (w == WORD_PHY_LAST) begin
            last = 1'b1;
         end
      end else if (w == WORD_POWER) begin
         last = 1'b1;
      end
      return {last, nw};
   endfunction

   function automatic fn_advert_t derive(input logic [15:0] init);
      fn_advert_t a;
      a.pmeEnableAnyState    = init[INIT_WAKE_BIT];                       // [R8]
      a.pmeSupport           = PME_NONE;
      if (init[INIT_WAKE_BIT]) begin
         a.pmeSupport = PME_WAKE;                                         // [R8]
         if (init[INIT_AUX_BIT]) begin
            a.pmeSupport = PME_WAKE | PME_D3COLD;                         // [R7]
         end
      end
      a.ioSpaceRequest       = !init[INIT_IO_DIS_BIT];                    // [R11]
      a.bar2Reserved         = init[INIT_IO_DIS_BIT];                     // [R11]
      a.subsysIdHostWritable = init[INIT_SSID_WR_BIT];                    // [R10]
      return a;
   endfunction

   // ==========================================================================
   // Loader state
   always_comb begin
      logic [7:0] step;
      logic       takeShared;
      logic       takeFunction;
      step         = follow(s.sharedLoad, s.word);
      takeShared   = 1'b0;
      takeFunction = 1'b0;
      next_s = s;
      next_s.fetchStart  = 1'b0;
      next_s.phyCfgValid = 1'b0;

      unique case (s.state)
         LD_IDLE: begin
            if (s.sharedPending) begin
               takeShared = 1'b1;
               next_s.sharedLoad = 1'b1;
               next_s.word       = WORD_SHARED_INIT;                      // [R5]
               next_s.fetchStart = 1'b1;
               next_s.state      = LD_WAIT;
            end else if (s.functionPending) begin
               takeFunction = 1'b1;
               next_s.ident.subsysId       = SUBSYS_ID_RESET;             // [R14]
               next_s.ident.subsysVendorId = SUBSYS_VEN_RESET;            // [R20]
               next_s.ident.deviceId       = DEVICE_ID_RESET;             // [R20]
               next_s.pciInit     = PCI_INIT_RESET;
               next_s.power       = POWER_RESET;
               next_s.ssidWritten = 1'b0;
               if (s.imageValid) begin
                  next_s.sharedLoad = 1'b0;
                  next_s.word       = WORD_PCI_INIT;                      // [R6]
                  next_s.fetchStart = 1'b1;
                  next_s.state      = LD_WAIT;
               end
            end
         end
         LD_WAIT: begin
            if (rdDone) begin
               next_s.fetchStart = !step[7];
               next_s.word       = step[6:0];
               next_s.state      = step[7] ? LD_IDLE : LD_WAIT;
               if (s.sharedLoad) begin
                  if (s.word == WORD_SHARED_INIT) begin
                     next_s.imageValid = (rdData[SIGN_HI:SIGN_LO] == SIGN_VALID);
                     if (rdData[SIGN_HI:SIGN_LO] != SIGN_VALID) begin
                        next_s.fetchStart = 1'b0;                         // [R18]
                        next_s.state      = LD_IDLE;                      // [R18]
                     end
                  end else if (s.word == WORD_ADDR_FIRST) begin
                     next_s.stationAddress[15:0] = rdData;                // [R1] [R3]
                     next_s.addrIsMulticast = rdData[MCAST_BIT];          // [R4]
                     next_s.addrIsLocal     = rdData[LOCAL_BIT];          // [R4]
                  end else if (s.word == WORD_ADDR_MID) begin
                     next_s.stationAddress[31:16] = rdData;               // [R1]
                  end else if (s.word == WORD_ADDR_LAST) begin
                     next_s.stationAddress[47:32] = rdData;               // [R1]
                     next_s.rxAddrValid = 1'b1;                           // [R2]
                  end else if (s.word >= WORD_PHY_FIRST) begin
                     next_s.phyCfgValid = 1'b1;                           // [R17]
                     next_s.phyCfgIndex = 4'(s.word - WORD_PHY_FIRST);    // [R17]
                     next_s.phyCfgData  = rdData;                         // [R17]
                  end else begin
                     next_s.extConfig[16*(s.word - WORD_EXT_FIRST) +: 16] = rdData; // [R5]
                  end
               end else begin
                  unique case (s.word)
                     WORD_PCI_INIT: begin
                        next_s.pciInit = rdData;                          // [R6]
                     end
                     WORD_SUBSYS_ID: begin
                        if (s.pciInit[INIT_SUBSYS_BIT]) begin
                           next_s.ident.subsysId = rdData;                // [R12]
                        end
                     end
                     WORD_SUBSYS_VEN: begin
                        if (s.pciInit[INIT_SUBSYS_BIT]) begin
                           next_s.ident.subsysVendorId = rdData;          // [R12]
                        end
                     end
                     WORD_DEVICE_ID: begin
                        if (s.pciInit[INIT_DEVID_BIT]) begin
                           next_s.ident.deviceId = rdData;                // [R13]
                        end
                     end
                     WORD_POWER: begin
                        next_s.power = rdData;
                     end
                     default: begin
                        // Tracking words carry no hardware meaning [R15]
                     end
                  endcase
               end
            end
         end
         default: begin
            next_s.state = LD_IDLE;
         end
      endcase

      // One-time host subsystem id write
      if (hostSsidWrite && s.advert.subsysIdHostWritable && !s.ssidWritten &&
          !takeFunction) begin
         next_s.ident.subsysId = hostSsidData;                            // [R10]
         next_s.ssidWritten    = 1'b1;                                    // [R10]
      end

      // New requests win over the clear of their pending flag
      next_s.sharedPending   = (s.sharedPending && !takeShared) || sharedResetReq;
      next_s.functionPending = (s.functionPending && !takeFunction) || functionResetReq;
      next_s.advert = derive(next_s.pciInit);
      next_s.busy   = (next_s.state != LD_IDLE);
   end

   always_ff @(posedge mclk or negedge resetN) begin
      if (!resetN) begin
         s <= '{state: LD_IDLE, word: 7'h00, sharedLoad: 1'b0, fetchStart: 1'b0,
                sharedPending: 1'b1, functionPending: 1'b1, imageValid: 1'b0,
                ssidWritten: 1'b0, pciInit: PCI_INIT_RESET,
                stationAddress: ADDR_RESET, rxAddrValid: 1'b0,
                addrIsMulticast: 1'b0, addrIsLocal: 1'b0,
                ident: '{subsysId: SUBSYS_ID_RESET, subsysVendorId: SUBSYS_VEN_RESET,
                         deviceId: DEVICE_ID_RESET},
                advert: '{pmeEnableAnyState: 1'b1, pmeSupport: PME_WAKE | PME_D3COLD,
                          ioSpaceRequest: 1'b1, bar2Reserved: 1'b0,
                          subsysIdHostWritable: 1'b0},
                power: POWER_RESET, extConfig: EXT_RESET, phyCfgValid: 1'b0,
                phyCfgIndex: 4'h0, phyCfgData: 16'h0000, busy: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================================
   // Outputs
   assign rxAddrLow       = s.stationAddress[31:0];                       // [R2]
   assign rxAddrHigh      = s.stationAddress[47:32];                      // [R2]
   assign rxAddrValid     = s.rxAddrValid;
   assign addrIsMulticast = s.addrIsMulticast;
   assign addrIsLocal     = s.addrIsLocal;
   assign imageValid      = s.imageValid;
   assign loadBusy        = s.busy;
   assign ident           = s.ident;
   assign advert          = s.advert;
   assign lanD0Power      = s.power[15:8];
   assign lanD3Power      = s.power[4:0];
   assign extConfig       = s.extConfig;
   assign phyCfgValid     = s.phyCfgValid;
   assign phyCfgIndex     = s.phyCfgIndex;
   assign phyCfgData      = s.phyCfgData;

endmodule

// ==== rtl/nvm_loader_pkg.sv ====
/*
 Constants, field positions, reset values and carrier types for the LAN image
 word loader. Assumes a 16-bit word image addressed in bytes within the LAN region.
*/
package nvm_loader_pkg;

   // ==========================================================================
   // Image word indices
   localparam logic [6:0] WORD_ADDR_FIRST  = 7'h00;
   localparam logic [6:0] WORD_ADDR_MID    = 7'h01;
   localparam logic [6:0] WORD_ADDR_LAST   = 7'h02;
   localparam logic [6:0] WORD_PCI_INIT    = 7'h0A;
   localparam logic [6:0] WORD_SUBSYS_ID   = 7'h0B;
   localparam logic [6:0] WORD_SUBSYS_VEN  = 7'h0C;
   localparam logic [6:0] WORD_DEVICE_ID   = 7'h0D;
   localparam logic [6:0] WORD_POWER       = 7'h10;
   localparam logic [6:0] WORD_SHARED_INIT = 7'h13;
   localparam logic [6:0] WORD_EXT_FIRST   = 7'h14;
   localparam logic [6:0] WORD_EXT_LAST    = 7'h18;
   localparam logic [6:0] WORD_PHY_FIRST   = 7'h40;
   localparam logic [6:0] WORD_PHY_LAST    = 7'h4A;

   // ==========================================================================
   // Field positions
   localparam int INIT_AUX_BIT     = 7;
   localparam int INIT_WAKE_BIT    = 6;
   localparam int INIT_SSID_WR_BIT = 3;
   localparam int INIT_IO_DIS_BIT  = 2;
   localparam int INIT_SUBSYS_BIT  = 1;
   localparam int INIT_DEVID_BIT   = 0;
   localparam int SIGN_HI          = 15;
   localparam int SIGN_LO          = 14;
   localparam int MCAST_BIT        = 0;
   localparam int LOCAL_BIT        = 1;
   localparam logic [1:0] SIGN_VALID = 2'b10;

   // ==========================================================================
   // Reset values
   localparam logic [15:0] PCI_INIT_RESET   = 16'h10C3;
   localparam logic [15:0] SUBSYS_ID_RESET  = 16'h0000;
   // Arbitrary neutral identifier values
   localparam logic [15:0] SUBSYS_VEN_RESET = 16'hA5A5;
   localparam logic [15:0] DEVICE_ID_RESET  = 16'h5A5A;
   localparam logic [15:0] POWER_RESET      = 16'h0702;
   localparam logic [47:0] ADDR_RESET       = 48'h0000_0000_0000;
   localparam logic [79:0] EXT_RESET        = 80'h0000_0000_0000_0000_0000;
   // PME support bits: D0, D1, D2, D3hot, D3cold
   localparam logic [4:0]  PME_WAKE         = 5'h09;
   localparam logic [4:0]  PME_D3COLD       = 5'h10;
   localparam logic [4:0]  PME_NONE         = 5'h00;

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_WAIT = 2'b01
   } load_state_t;

   typedef enum logic {
      RD_IDLE = 1'b0,
      RD_BUSY = 1'b1
   } read_state_t;

   typedef struct packed {
      logic [15:0] subsysId;
      logic [15:0] subsysVendorId;
      logic [15:0] deviceId;
   } pci_ident_t;

   typedef struct packed {
      logic       pmeEnableAnyState;
      logic [4:0] pmeSupport;
      logic       ioSpaceRequest;
      logic       bar2Reserved;
      logic       subsysIdHostWritable;
   } fn_advert_t;

   typedef struct packed {
      read_state_t state;
      logic        flashReq;
      logic [7:0]  flashByteAddr;
      logic        done;
      logic [15:0] data;
   } reader_t;

   typedef struct packed {
      load_state_t state;
      logic        busy;
      logic [6:0]  word;
      logic        sharedLoad;
      logic        fetchStart;
      logic        sharedPending;
      logic        functionPending;
      logic        imageValid;
      logic        ssidWritten;
      logic [15:0] pciInit;
      logic [47:0] stationAddress;
      logic        rxAddrValid;
      logic        addrIsMulticast;
      logic        addrIsLocal;
      pci_ident_t  ident;
      fn_advert_t  advert;
      logic [15:0] power;
      logic [79:0] extConfig;
      logic        phyCfgValid;
      logic [3:0]  phyCfgIndex;
      logic [15:0] phyCfgData;
   } loader_t;

endpackage

// ==== tb/flash_image_model.sv ====
/*
 Flash model holding the LAN image, one word per request.
 Assumes a same-clock request and one-cycle acknowledge.
*/
`timescale 1ns/100ps

module flash_image_model (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       flashReq,
   input  wire logic [7:0] flashByteAddr,
   output logic            flashAck,
   output logic [15:0]     flashData,
   output int              nReads
);
   logic [15:0] mem [0:127];
   logic [1:0]  waitCnt;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flashAck <= 1'b0;
         flashData <= 16'h0000;
         waitCnt <= 2'd0;
         nReads <= 0;
      end else if (flashReq && !flashAck && waitCnt == 2'd0) begin
         flashAck <= 1'b1;
         flashData <= mem[flashByteAddr[7:1]];
         nReads <= nReads + 1;
         waitCnt <= 2'($urandom_range(2));
      end else begin
         flashAck <= 1'b0;
         // Data not held outside the answer cycle
         flashData <= ~flashData;
         if (flashReq && waitCnt != 2'd0) begin
            waitCnt <= waitCnt - 2'd1;
         end
      end
   end
endmodule

// ==== tb/lan_nvm_word_loader_assertions.sv ====
/*
 Port assertions for the LAN image word loader.
 Assumes one mclk domain and the active-low rstn.
*/
`timescale 1ns/100ps

module lan_nvm_word_loader_assertions
   import nvm_loader_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        sharedResetReq,
   input wire logic        flashAck,
   input wire logic        flashReq,
   input wire logic [7:0]  flashByteAddr,
   input wire logic [31:0] rxAddrLow,
   input wire logic        rxAddrValid,
   input wire logic        addrIsMulticast,
   input wire logic        addrIsLocal,
   input wire logic        loadBusy,
   input wire fn_advert_t  advert,
   input wire logic        phyCfgValid,
   input wire logic [3:0]  phyCfgIndex
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   // ==========================================================================
   // Flash port
   chk_addr_even: assert property (flashReq |-> !flashByteAddr[0])
      else $error("odd address");
   chk_addr_range: assert property (flashReq |-> flashByteAddr <= 8'h94)
      else $error("address past image");
   chk_req_hold: assert property (flashReq && !flashAck |=> flashReq && $stable(flashByteAddr))
      else $error("request not held");
   chk_req_gap: assert property (flashReq && flashAck |=> !flashReq [*2])
      else $error("request too soon");
   chk_read_in_load: assert property (flashReq |-> loadBusy)
      else $error("read while idle");
   chk_busy_start: assert property (sharedResetReq && !loadBusy |-> ##[1:2] loadBusy)
      else $error("no load after reset");

   // ==========================================================================
   // Address and advertisement
   chk_mcast_flag: assert property (addrIsMulticast == rxAddrLow[MCAST_BIT])
      else $error("multicast flag wrong");
   chk_local_flag: assert property (addrIsLocal == rxAddrLow[LOCAL_BIT])
      else $error("local flag wrong");
   chk_rx_sticky: assert property (rxAddrValid |=> rxAddrValid)
      else $error("address valid dropped");
   chk_pme_none: assert property (!advert.pmeEnableAnyState |-> advert.pmeSupport == PME_NONE)
      else $error("PME without wake");
   chk_pme_wake: assert property (advert.pmeEnableAnyState |-> advert.pmeSupport[3:0] == 4'h9)
      else $error("wrong PME support");
   chk_io_bar: assert property (advert.ioSpaceRequest != advert.bar2Reserved)
      else $error("I/O and BAR 2 disagree");
   chk_phy_index: assert property (phyCfgValid |-> phyCfgIndex <= 4'd10)
      else $error("phy index out of range");
endmodule

bind lan_nvm_word_loader lan_nvm_word_loader_assertions u_chk (
   .mclk(mclk), .rstn(rstn), .sharedResetReq(sharedResetReq), .flashAck(flashAck),
   .flashReq(flashReq), .flashByteAddr(flashByteAddr), .rxAddrLow(rxAddrLow),
   .rxAddrValid(rxAddrValid), .addrIsMulticast(addrIsMulticast), .addrIsLocal(addrIsLocal),
   .loadBusy(loadBusy), .advert(advert), .phyCfgValid(phyCfgValid), .phyCfgIndex(phyCfgIndex)
);

// ==== tb/lan_nvm_word_loader_tb.sv ====
/*
 Self-checking bench for the LAN image word loader.
 Assumes the flash model and the bound checker.
*/
`timescale 1ns/100ps

module lan_nvm_word_loader_tb
   import nvm_loader_pkg::*;
();
   localparam logic [15:0] SUM_TARGET = 16'hBABA;
   logic        mclk, rstn, sharedResetReq, functionResetReq, hostSsidWrite;
   logic [15:0] hostSsidData, flashData, phyCfgData, rxAddrHigh;
   logic        flashAck, flashReq, rxAddrValid, addrIsMulticast, addrIsLocal;
   logic        imageValid, loadBusy, phyCfgValid;
   logic [7:0]  flashByteAddr, lanD0Power;
   logic [31:0] rxAddrLow;
   logic [4:0]  lanD3Power;
   logic [79:0] extConfig;
   logic [3:0]  phyCfgIndex;
   pci_ident_t  ident;
   fn_advert_t  advert;
   int          failures = 0, nChecks = 0, nReads, phyCount = 0, cycles = 0;

   lan_nvm_word_loader u_lan_nvm_word_loader (
      .mclk(mclk), .rstn(rstn), .sharedResetReq(sharedResetReq),
      .functionResetReq(functionResetReq), .flashAck(flashAck), .flashData(flashData),
      .hostSsidWrite(hostSsidWrite), .hostSsidData(hostSsidData), .flashReq(flashReq),
      .flashByteAddr(flashByteAddr), .rxAddrLow(rxAddrLow), .rxAddrHigh(rxAddrHigh),
      .rxAddrValid(rxAddrValid), .addrIsMulticast(addrIsMulticast), .addrIsLocal(addrIsLocal),
      .imageValid(imageValid), .loadBusy(loadBusy), .ident(ident), .advert(advert),
      .lanD0Power(lanD0Power), .lanD3Power(lanD3Power), .extConfig(extConfig),
      .phyCfgValid(phyCfgValid), .phyCfgIndex(phyCfgIndex), .phyCfgData(phyCfgData));
   flash_image_model u_flash_image_model (
      .mclk(mclk), .rstn(rstn), .flashReq(flashReq), .flashByteAddr(flashByteAddr),
      .flashAck(flashAck), .flashData(flashData), .nReads(nReads));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // ==========================================================================
   // Helpers
   function automatic logic [15:0] img(input int i);
      return u_flash_image_model.mem[i];
   endfunction

   function automatic fn_advert_t exp_advert(input logic [15:0] w);
      logic [4:0] pme;
      pme = w[6] ? (w[7] ? 5'h19 : 5'h09) : 5'h00;
      return {w[6], pme, !w[2], w[2], w[3]};
   endfunction

   task automatic end_sim;
      if (failures == 0 && nChecks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      nChecks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic pulse(input logic [1:0] which);
      @(posedge mclk);
      sharedResetReq <= which[0];
      functionResetReq <= which[1];
      @(posedge mclk);
      sharedResetReq <= 1'b0;
      functionResetReq <= 1'b0;
   endtask

   task automatic wait_idle;
      int quiet = 0;
      for (int i = 0; i < 3000 && quiet < 4; i++) begin
         @(posedge mclk);
         quiet = (loadBusy === 1'b0) ? quiet + 1 : 0;
      end
      #1;
      check(quiet >= 4, 1'b1);
   endtask

   task automatic build_image(input logic [1:0] sign, input logic [15:0] init);
      logic [15:0] sum;
      sum = 16'h0000;
      for (int i = 0; i < 128; i++) u_flash_image_model.mem[i] = 16'($urandom);
      u_flash_image_model.mem[WORD_PCI_INIT] = init & 16'hFFCF;
      u_flash_image_model.mem[WORD_SHARED_INIT][15:14] = sign;
      for (int i = 0; i < 63; i++) sum = sum + img(i);
      u_flash_image_model.mem[7'h3F] = SUM_TARGET - sum;
   endtask

   task automatic host_write(input logic [15:0] d);
      @(posedge mclk);
      hostSsidWrite <= 1'b1;
      hostSsidData <= d;
      @(posedge mclk);
      hostSsidWrite <= 1'b0;
      @(posedge mclk);
      #1;
   endtask

   task automatic check_loads(input logic [15:0] init, input int phyBase);
      logic [15:0] p;
      p = img(WORD_POWER);
      check(rxAddrLow, {img(1), img(0)});
      check(rxAddrHigh, img(2));
      check(rxAddrValid, 1'b1);
      check(imageValid, 1'b1);
      check(extConfig, {img(24), img(23), img(22), img(21), img(20)});
      check(phyCount - phyBase, 11);
      check(advert, exp_advert(init));
      check(ident.subsysId, init[1] ? img(11) : SUBSYS_ID_RESET);
      check(ident.subsysVendorId, init[1] ? img(12) : SUBSYS_VEN_RESET);
      check(ident.deviceId, init[0] ? img(13) : DEVICE_ID_RESET);
      check({lanD0Power, lanD3Power}, {p[15:8], p[4:0]});
   endtask

   always @(posedge mclk) begin
      if (phyCfgValid === 1'b1) begin
         check(phyCfgData, img(7'h40 + phyCfgIndex));
         phyCount++;
      end
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   // ==========================================================================
   // Main sequence
   initial begin
      logic [15:0] init, d, expSsid;
      int          readBase;
      rstn = 1'b0;
      sharedResetReq = 1'b0;
      functionResetReq = 1'b0;
      hostSsidWrite = 1'b0;
      hostSsidData = 16'h0000;
      void'($urandom(32'hb72111f3));
      build_image(2'b10, 16'h00C3);
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      wait_idle();
      check_loads(16'h00C3, 0);
      for (int i = 0; i < 8; i++) begin
         init = (i == 0) ? 16'h0000 : (i == 1) ? 16'h00CF : 16'($urandom);
         build_image(2'b10, init);
         readBase = phyCount;
         if (i[0]) begin
            pulse(2'b11);
         end else begin
            pulse(2'b01);
            wait_idle();
            pulse(2'b10);
         end
         wait_idle();
         check_loads(init, readBase);
         expSsid = init[1] ? img(11) : SUBSYS_ID_RESET;
         d = 16'($urandom);
         host_write(d);
         if (init[INIT_SSID_WR_BIT]) expSsid = d;
         check(ident.subsysId, expSsid);
         host_write(~d);
         check(ident.subsysId, expSsid);
      end
      pulse(2'b01);
      repeat (4) @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      check({rxAddrValid, imageValid, flashReq}, 3'b000);
      check(ident, {SUBSYS_ID_RESET, SUBSYS_VEN_RESET, DEVICE_ID_RESET});
      build_image(2'b01, 16'h00CF);
      readBase = nReads;
      @(posedge mclk);
      rstn <= 1'b1;
      wait_idle();
      check(imageValid, 1'b0);
      check(nReads - readBase, 1);
      check(ident, {SUBSYS_ID_RESET, SUBSYS_VEN_RESET, DEVICE_ID_RESET});
      check(advert, exp_advert(PCI_INIT_RESET));
      end_sim();
   end
endmodule
